// [rtl/llf_div_if.sv]
`timescale 1ns/1ps
interface llf_div_if;
    logic start;
    logic [47:0] dividend;
    logic [31:0] divisor;
    logic done;
    logic [47:0] quotient;

    modport requester (output start, output dividend, output divisor,
                       input done, input quotient);
    modport server (input start, input dividend, input divisor,
                    output done, output quotient);
endinterface

// [rtl/llf_divider.sv]
`timescale 1ns/1ps
module llf_divider (
    input wire logic clk_in,
    input wire logic reset_n_in,
    llf_div_if.server div
);
    import llf_pkg::*;

    typedef struct packed {
        logic busy;
        logic done;
        logic [5:0] cnt;
        logic [32:0] rem;
        logic [47:0] quo;
        logic [31:0] dvs;
    } llf_div_s;

    llf_div_s q, d;
    logic [32:0] shifted;

    // ************************************************************
    // Restoring division, one quotient bit per clock
    // ************************************************************
    always_comb begin
        d = q;
        d.done = 1'b0;
        shifted = {q.rem[31:0], q.quo[47]};
        if (!q.busy && div.start) begin
            d.busy = 1'b1;
            d.cnt = DIV_BITS;
            d.rem = '0;
            d.quo = div.dividend;
            d.dvs = div.divisor;
        end else if (q.busy) begin
            // Zero divisor yields all ones, read by the caller as saturation
            if (shifted >= {1'b0, q.dvs}) begin
                d.rem = shifted - {1'b0, q.dvs};
                d.quo = {q.quo[46:0], 1'b1};
            end else begin
                d.rem = shifted;
                d.quo = {q.quo[46:0], 1'b0};
            end
            d.cnt = q.cnt - 6'h01;
            if (q.cnt == 6'h01) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign div.done = q.done;
    assign div.quotient = q.quo;

endmodule

// [rtl/llf_lag_filter.sv]
`timescale 1ns/1ps
module llf_lag_filter #(
    parameter int LAG_CYCLES = llf_pkg::LAG_UNIT_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [15:0] current_in,
    input wire logic [11:0] filt_set_in,
    output logic [15:0] filt_out
);
    import llf_pkg::*;

    typedef struct packed {
        logic [31:0] phase;
        logic [23:0] acc;
        logic [15:0] y;
    } llf_lag_s;

    llf_lag_s q, d;
    logic [31:0] thr;
    logic [31:0] nxt;
    logic [16:0] diff;

    // ************************************************************
    // First-order lag, stepped at time constant / 2^FILT_SHIFT
    // ************************************************************
    // A phase accumulator sets the step rate, so no divider is needed
    always_comb begin
        d = q;
        thr = 32'(filt_set_in) * 32'(LAG_CYCLES);
        nxt = q.phase + FILT_STEP;
        diff = {1'b0, current_in} - {1'b0, q.y};
        if (nxt >= thr) begin
            d.phase = nxt - thr;
            d.acc = q.acc + {{7{diff[16]}}, diff}; // R6
        end else begin
            d.phase = nxt;
        end
        d.y = d.acc[FILT_SHIFT +: 16];
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign filt_out = q.y;

endmodule

// [rtl/llf_pkg.sv]
package llf_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 4;
    // Lag time constant per unit of the filter setting, 0.75 ms
    localparam int LAG_FACTOR_US = 750;
    localparam int LAG_UNIT_CYCLES = LAG_FACTOR_US * 1000 / CLK_PERIOD_NS;
    // Filter gain is 1/2^FILT_SHIFT per sub-step; steps scale with the setting
    localparam int FILT_SHIFT = 8;
    localparam logic [31:0] FILT_STEP = 32'h0000_0001 << FILT_SHIFT;
    localparam logic [5:0] DIV_BITS = 6'h30;

    // ************************************************************
    // Settings: frequency in 0.1 Hz, current thresholds in 1 % of rated
    // ************************************************************
    localparam logic [15:0] HIGH_FREQ_DEF = 16'h0258;
    localparam logic [15:0] MID_FREQ_DEF = 16'h012C;
    localparam logic [15:0] FREQ_SET_MAX = 16'h0FA0;
    localparam logic [15:0] FREQ_CLAMP = 16'h04B0;
    localparam logic [15:0] AVG_RANGE_UNSET = 16'h270F;
    localparam logic [7:0] HIGH_CUR_DEF = 8'h32;
    localparam logic [7:0] MID_CUR_DEF = 8'h64;
    localparam logic [7:0] CUR_PCT_MAX = 8'hDC;
    localparam logic [15:0] PCT_SCALE = 16'h000A;
    localparam logic [11:0] FILT_DEF = 12'h010;
    localparam logic [11:0] FILT_MIN = 12'h001;
    localparam logic [11:0] FILT_MAX = 12'hFA0;
    localparam logic [1:0] CTRL_DEF = 2'h0;
    localparam logic [1:0] CTRL_LIGHT = 2'h2;
    localparam logic [1:0] CTRL_LIGHT_STOP = 2'h3;
    // Average below this is taken as regeneration
    localparam logic [15:0] REGEN_FLOOR = 16'h000A;

    // ************************************************************
    // Setting write select codes
    // ************************************************************
    localparam logic [2:0] SEL_HIGH_FREQ = 3'h0;
    localparam logic [2:0] SEL_MID_FREQ = 3'h1;
    localparam logic [2:0] SEL_HIGH_CUR = 3'h2;
    localparam logic [2:0] SEL_MID_CUR = 3'h3;
    localparam logic [2:0] SEL_AVG_RANGE = 3'h4;
    localparam logic [2:0] SEL_FILT = 3'h5;
    localparam logic [2:0] SEL_CTRL = 3'h6;

    // ************************************************************
    // Synchronised pin positions
    // ************************************************************
    localparam int PIN_BOOST = 0;
    localparam int PIN_JOG = 1;
    localparam int PIN_PROC = 2;
    localparam int PIN_MS_HIGH = 3;
    localparam int PIN_MS_MID = 4;
    localparam int PIN_MS_LOW = 5;
    localparam int PIN_COUNT = 6;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WAIT = 6'h02,
        ST_AVG = 6'h04,
        ST_DIV_AVG = 6'h08,
        ST_DIV_INT = 6'h10,
        ST_APPLY = 6'h20
    } llf_state_e;

endpackage

// [rtl/llf_top.sv]
// Summary of operation
// R1 - Function enabled only for selection 2 or 3
// R2 - High-speed frequency, default 60 Hz, 0-400
// R3 - Middle-speed frequency, default 30 Hz, 0-400
// R4 - Current thresholds 0-220 %, defaults 50/100
// R5 - Average between half range and range
// R6 - Lag filter constant 0.75 ms per step
// R7 - Select input sets maximum between both settings
// R8 - Other party assigns select input to terminal
// R9 - Active only in external operation mode
// R10 - Selection is made anew at every start
// R11 - Below high threshold: high-speed is maximum
// R12 - Above middle threshold: middle-speed is maximum
// R13 - Regeneration or tiny average forces middle-speed
// R14 - Output frequency clamped to 120 Hz
// R15 - Fast current limit disabled while active
// R16 - Listed operating conditions disable the function
// R17 - Between thresholds, interpolate linearly
`timescale 1ns/1ps
module llf_top #(
    parameter int LAG_CYCLES = llf_pkg::LAG_UNIT_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic param_wr_in,
    input wire logic [2:0] param_sel_in,
    input wire logic [15:0] param_data_in,
    input wire logic light_load_boost_select_in,
    input wire logic jog_in,
    input wire logic process_control_select_in,
    input wire logic multi_speed_high_input_in,
    input wire logic multi_speed_middle_input_in,
    input wire logic multi_speed_low_input_in,
    input wire logic external_mode_in,
    input wire logic panel_mode_in,
    input wire logic panel_external_mode_in,
    input wire logic remote_setting_in,
    input wire logic orientation_in,
    input wire logic digital_option_in,
    input wire logic run_in,
    input wire logic accelerating_in,
    input wire logic regenerating_in,
    input wire logic [15:0] output_freq_in,
    input wire logic [15:0] output_current_in,
    input wire logic [15:0] freq_cmd_in,
    output logic [15:0] max_freq_out,
    output logic [15:0] freq_cmd_out,
    output logic [15:0] avg_current_out,
    output logic active_out,
    output logic fast_limit_disable_out,
    output logic averaging_out,
    output logic decided_out
);
    import llf_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [PIN_COUNT-1:0] sync1;
        logic [PIN_COUNT-1:0] sync2;
        logic [PIN_COUNT-1:0] sync3;
        logic [PIN_COUNT-1:0] pins;
        logic [15:0] high_freq;
        logic [15:0] mid_freq;
        logic [7:0] high_cur;
        logic [7:0] mid_cur;
        logic [15:0] avg_range;
        logic [11:0] filt_set;
        logic [1:0] ctrl_sel;
        logic run_prev;
        llf_state_e state;
        logic regen_seen;
        logic [47:0] sum;
        logic [31:0] cnt;
        logic [15:0] avg;
        logic [15:0] max_freq;
        logic [15:0] freq_cmd;
        logic active;
        logic fast_dis;
        logic averaging;
        logic decided;
        logic div_start;
        logic [47:0] div_dividend;
        logic [31:0] div_divisor;
    } llf_top_s;

    localparam llf_top_s RESET_STATE = '{
        high_freq: HIGH_FREQ_DEF,
        mid_freq: MID_FREQ_DEF,
        high_cur: HIGH_CUR_DEF,
        mid_cur: MID_CUR_DEF,
        avg_range: AVG_RANGE_UNSET,
        filt_set: FILT_DEF,
        ctrl_sel: CTRL_DEF,
        state: ST_IDLE,
        default: '0
    };

    llf_top_s q, d;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] clamp_freq(input logic [15:0] f);
        clamp_freq = (f > FREQ_CLAMP) ? FREQ_CLAMP : f;
    endfunction

    function automatic logic [15:0] pct_to_level(input logic [7:0] p);
        pct_to_level = 16'({8'h00, p} * PCT_SCALE);
    endfunction

    // ************************************************************
    // Submodules
    // ************************************************************
    logic [15:0] filt_cur;
    llf_div_if div ();

    llf_lag_filter #(
        .LAG_CYCLES(LAG_CYCLES)
    ) u_filter (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .current_in(output_current_in),
        .filt_set_in(q.filt_set),
        .filt_out(filt_cur)
    );

    llf_divider u_div (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .div(div.server)
    );

    assign div.start = q.div_start;
    assign div.dividend = q.div_dividend;
    assign div.divisor = q.div_divisor;

    // ************************************************************
    // Enable and averaging window
    // ************************************************************
    logic [PIN_COUNT-1:0] pins_raw;
    logic [PIN_COUNT-1:0] agree;
    logic sel_ok;
    logic inhibit;
    logic enabled;
    logic [15:0] win_top;
    logic [15:0] win_lo;
    logic [15:0] lo_level;
    logic [15:0] hi_level;
    logic [15:0] avg_sat;
    logic [15:0] span;
    logic [15:0] interp;

    assign pins_raw = {multi_speed_low_input_in, multi_speed_middle_input_in,
                       multi_speed_high_input_in, process_control_select_in,
                       jog_in, light_load_boost_select_in};
    assign agree = ~(q.sync2 ^ q.sync3);
    assign sel_ok = (q.ctrl_sel == CTRL_LIGHT) || (q.ctrl_sel == CTRL_LIGHT_STOP); // R1
    assign inhibit = panel_mode_in || panel_external_mode_in || q.pins[PIN_JOG]
                     || q.pins[PIN_PROC] || remote_setting_in || orientation_in
                     || q.pins[PIN_MS_HIGH] || q.pins[PIN_MS_MID]
                     || q.pins[PIN_MS_LOW] || digital_option_in; // R16
    // Select pin is read as mapped by the terminal assignment
    assign enabled = sel_ok && external_mode_in && !inhibit
                     && q.pins[PIN_BOOST]; // R7 R8 R9
    assign win_top = (q.avg_range == AVG_RANGE_UNSET) ? q.mid_freq : q.avg_range; // R5
    assign win_lo = {1'b0, win_top[15:1]}; // R5
    assign lo_level = pct_to_level(q.high_cur);
    assign hi_level = pct_to_level(q.mid_cur);
    assign avg_sat = (div.quotient[47:16] != 32'h0) ? 16'hFFFF : div.quotient[15:0];
    assign span = (q.high_freq >= q.mid_freq) ? (q.high_freq - q.mid_freq)
                                              : (q.mid_freq - q.high_freq);
    assign interp = (q.high_freq >= q.mid_freq) ? (q.high_freq - div.quotient[15:0])
                                                : (q.high_freq + div.quotient[15:0]);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d = q;
        d.div_start = 1'b0;

        // Pins settle once the last two stages agree
        d.sync1 = pins_raw;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        d.pins = (agree & q.sync3) | (~agree & q.pins);

        // Out-of-range writes are dropped, old value kept
        if (param_wr_in) begin
            if (param_sel_in == SEL_HIGH_FREQ) begin
                if (param_data_in <= FREQ_SET_MAX) d.high_freq = param_data_in; // R2
            end else if (param_sel_in == SEL_MID_FREQ) begin
                if (param_data_in <= FREQ_SET_MAX) d.mid_freq = param_data_in; // R3
            end else if (param_sel_in == SEL_HIGH_CUR) begin
                if (param_data_in <= {8'h00, CUR_PCT_MAX}) d.high_cur = param_data_in[7:0]; // R4
            end else if (param_sel_in == SEL_MID_CUR) begin
                if (param_data_in <= {8'h00, CUR_PCT_MAX}) d.mid_cur = param_data_in[7:0]; // R4
            end else if (param_sel_in == SEL_AVG_RANGE) begin
                if (param_data_in <= FREQ_SET_MAX || param_data_in == AVG_RANGE_UNSET) begin
                    d.avg_range = param_data_in; // R5
                end
            end else if (param_sel_in == SEL_FILT) begin
                if (param_data_in >= {4'h0, FILT_MIN} && param_data_in <= {4'h0, FILT_MAX}) begin
                    d.filt_set = param_data_in[11:0]; // R6
                end
            end else if (param_sel_in == SEL_CTRL) begin
                if (param_data_in <= {14'h0000, CTRL_LIGHT_STOP}) begin
                    d.ctrl_sel = param_data_in[1:0]; // R1
                end
            end
        end

        d.run_prev = run_in;

        case (q.state)
            ST_IDLE: begin
                if (run_in && !q.run_prev && enabled) begin
                    d.state = ST_WAIT; // R10
                    d.sum = '0;
                    d.cnt = '0;
                    d.regen_seen = 1'b0;
                    d.decided = 1'b0;
                    d.max_freq = clamp_freq(win_top);
                end
            end
            ST_WAIT: begin
                if (accelerating_in && output_freq_in >= win_lo) begin
                    d.state = ST_AVG; // R5
                end
            end
            ST_AVG: begin
                d.sum = q.sum + {32'h0000_0000, filt_cur}; // R5
                d.cnt = q.cnt + 32'h0000_0001;
                d.regen_seen = q.regen_seen || regenerating_in;
                // Ending acceleration early closes the window with what it has
                if (output_freq_in >= win_top || !accelerating_in) begin
                    d.state = ST_DIV_AVG;
                    d.div_start = 1'b1;
                    d.div_dividend = q.sum;
                    d.div_divisor = q.cnt;
                end
            end
            ST_DIV_AVG: begin
                if (div.done) begin
                    d.avg = avg_sat;
                    d.state = ST_APPLY;
                    d.decided = 1'b1;
                    if (q.regen_seen || avg_sat < REGEN_FLOOR) begin
                        d.max_freq = clamp_freq(q.mid_freq); // R13
                    end else if (avg_sat < lo_level) begin
                        d.max_freq = clamp_freq(q.high_freq); // R11
                    end else if (avg_sat > hi_level || hi_level == lo_level) begin
                        d.max_freq = clamp_freq(q.mid_freq); // R12
                    end else begin
                        d.state = ST_DIV_INT; // R17
                        d.decided = 1'b0;
                        d.div_start = 1'b1;
                        d.div_dividend = {16'h0000, span} * {32'h0, avg_sat - lo_level};
                        d.div_divisor = {16'h0000, hi_level - lo_level};
                    end
                end
            end
            ST_DIV_INT: begin
                if (div.done) begin
                    d.max_freq = clamp_freq(interp); // R17 R14
                    d.decided = 1'b1;
                    d.state = ST_APPLY;
                end
            end
            ST_APPLY: begin
                d.state = ST_APPLY;
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase

        // A stop or a disabling condition drops the selection
        if (q.state != ST_IDLE && !(enabled && run_in)) begin
            d.state = ST_IDLE; // R10
            d.decided = 1'b0;
        end

        d.active = enabled && run_in;
        d.fast_dis = enabled && run_in; // R15
        d.averaging = (d.state == ST_AVG);
        if (d.active) begin
            d.freq_cmd = (freq_cmd_in > clamp_freq(d.max_freq)) ? clamp_freq(d.max_freq)
                                                                 : freq_cmd_in; // R14
        end else begin
            d.freq_cmd = freq_cmd_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign max_freq_out = q.max_freq;
    assign freq_cmd_out = q.freq_cmd;
    assign avg_current_out = q.avg;
    assign active_out = q.active;
    assign fast_limit_disable_out = q.fast_dis;
    assign averaging_out = q.averaging;
    assign decided_out = q.decided;

endmodule

// [test/llf_drive_model.sv]
`timescale 1ns/1ps
// ****************************************
// Motor and current sensing
// ****************************************
module llf_drive_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic run_in,
    input wire logic [15:0] cur_in,
    input wire logic regen_in,
    output logic [15:0] freq_out,
    output logic [15:0] current_out,
    output logic accel_out,
    output logic regen_out
);
    // Fixed ramp; load current stands at rest too, so the lag filter settles
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            freq_out <= 16'h0000;
            current_out <= 16'h0000;
            accel_out <= 1'b0;
            regen_out <= 1'b0;
        end else begin
            current_out <= cur_in;
            regen_out <= run_in & regen_in;
            accel_out <= run_in && freq_out < 16'h02BC;
            freq_out <= !run_in ? 16'h0000 : freq_out + {14'h0000, freq_out < 16'h02BC, 1'b0};
        end
    end
endmodule

// [test/llf_top_chk.sv]
`timescale 1ns/1ps
// ****************************************
// Port checks for the light-load limit
// ****************************************
module llf_top_chk (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic jog_in,
    input wire logic light_load_boost_select_in,
    input wire logic external_mode_in,
    input wire logic panel_mode_in,
    input wire logic digital_option_in,
    input wire logic run_in,
    input wire logic accelerating_in,
    input wire logic [15:0] max_freq_out,
    input wire logic [15:0] freq_cmd_out,
    input wire logic active_out,
    input wire logic fast_limit_disable_out,
    input wire logic averaging_out,
    input wire logic decided_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_fast; fast_limit_disable_out == active_out; endproperty
    a_fast: assert property (p_fast) else $error("fast limit flag differs");
    property p_clamp; max_freq_out <= 16'h04B0 && (!active_out || freq_cmd_out <= 16'h04B0);
    endproperty
    a_clamp: assert property (p_clamp) else $error("frequency above ceiling");
    property p_ext; !external_mode_in |=> !active_out; endproperty
    a_ext: assert property (p_ext) else $error("active outside external mode");
    property p_inh; panel_mode_in || digital_option_in |=> !active_out; endproperty
    a_inh: assert property (p_inh) else $error("active while inhibited");
    // Pins pass a three-flop synchroniser, so allow five samples
    property p_sync; jog_in [*5] or (!light_load_boost_select_in) [*5] |=> !active_out; endproperty
    a_sync: assert property (p_sync) else $error("active with pin inhibit");
    property p_run; !run_in |=> !active_out && !decided_out; endproperty
    a_run: assert property (p_run) else $error("state kept after stop");
    property p_dec; $fell(averaging_out) && run_in |-> ##[1:120] decided_out; endproperty
    a_dec: assert property (p_dec) else $error("no decision after window");
    property p_hold; decided_out && $past(decided_out) |-> $stable(max_freq_out); endproperty
    a_hold: assert property (p_hold) else $error("limit moved within a run");
    property p_win; !accelerating_in |=> !averaging_out; endproperty
    a_win: assert property (p_win) else $error("averaging without acceleration");
endmodule

bind llf_top llf_top_chk chk_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .jog_in(jog_in),
    .light_load_boost_select_in(light_load_boost_select_in), .run_in(run_in),
    .external_mode_in(external_mode_in), .panel_mode_in(panel_mode_in),
    .digital_option_in(digital_option_in), .accelerating_in(accelerating_in),
    .max_freq_out(max_freq_out), .freq_cmd_out(freq_cmd_out), .active_out(active_out),
    .fast_limit_disable_out(fast_limit_disable_out), .averaging_out(averaging_out),
    .decided_out(decided_out));

// [test/llf_top_tb.sv]
`timescale 1ns/1ps
module llf_top_tb;
    import llf_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic param_wr_in = 1'b0;
    logic [2:0] param_sel_in = 3'h0;
    logic [15:0] param_data_in = 16'h0000;
    logic [11:0] inh = 12'h000;
    logic run_in = 1'b0;
    logic regen_set = 1'b0;
    logic [15:0] freq_cmd_in = 16'h0000;
    logic [15:0] cur_set = 16'h0000;
    logic [15:0] win_f = 16'h0000;
    logic [15:0] frq, cur, max_freq_out, freq_cmd_out, avg_current_out;
    logic acc, rgn, active_out, averaging_out, decided_out;
    logic dec_q = 1'b0;
    logic avg_q = 1'b0;
    logic [15:0] q_exp[$];
    int q_tol[$];
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;

    always #2 clk_in = ~clk_in;

    // Boost select wired to its terminal; inhibit bits one per condition
    llf_top #(.LAG_CYCLES(8)) dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .param_wr_in(param_wr_in), .param_sel_in(param_sel_in), .param_data_in(param_data_in),
        .light_load_boost_select_in(!inh[11]), .jog_in(inh[6]),
        .process_control_select_in(inh[7]), .multi_speed_high_input_in(inh[8]),
        .multi_speed_middle_input_in(inh[9]), .multi_speed_low_input_in(inh[10]),
        .external_mode_in(!inh[0]), .panel_mode_in(inh[1]), .panel_external_mode_in(inh[2]),
        .remote_setting_in(inh[3]), .orientation_in(inh[4]), .digital_option_in(inh[5]),
        .run_in(run_in), .accelerating_in(acc), .regenerating_in(rgn), .output_freq_in(frq),
        .output_current_in(cur), .freq_cmd_in(freq_cmd_in), .max_freq_out(max_freq_out),
        .freq_cmd_out(freq_cmd_out), .avg_current_out(avg_current_out), .active_out(active_out),
        .fast_limit_disable_out(), .averaging_out(averaging_out), .decided_out(decided_out));

    llf_drive_model plant_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .run_in(run_in),
        .cur_in(cur_set), .regen_in(regen_set), .freq_out(frq), .current_out(cur),
        .accel_out(acc), .regen_out(rgn));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp,
                         input int tol);
        logic ok;
        ok = ((got > exp) ? (got - exp) : (exp - got)) <= 16'(tol);
        num_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] sel, input logic [15:0] data);
        @(posedge clk_in);
        param_wr_in <= 1'b1;
        param_sel_in <= sel;
        param_data_in <= data;
        @(posedge clk_in);
        param_wr_in <= 1'b0;
    endtask

    // One start; the limit is compared by the monitor when the decision appears
    task automatic go(input logic [15:0] c, input logic rg, input logic [15:0] exp,
                      input int tol, input logic [15:0] wst);
        int n;
        @(posedge clk_in);
        cur_set <= c;
        regen_set <= rg;
        freq_cmd_in <= 16'($urandom_range(0, 4000));
        repeat (2000) @(posedge clk_in);
        run_in <= 1'b1;
        q_exp.push_back(exp);
        q_tol.push_back(tol);
        for (n = 0; n < 3000 && decided_out !== 1'b1; n++) @(posedge clk_in);
        #1;
        check("window", win_f, wst + 16'h0002, 3);
        if (!rg) check("average", avg_current_out, c, 4);
        @(posedge clk_in);
        run_in <= 1'b0;
        repeat (5) @(posedge clk_in);
    endtask

    always @(posedge clk_in) begin
        cycles++;
        dec_q <= decided_out;
        avg_q <= averaging_out;
        if (averaging_out === 1'b1 && avg_q !== 1'b1) win_f <= frq;
        if (decided_out === 1'b1 && dec_q !== 1'b1) begin
            if (q_exp.size() == 0) check("spurious", max_freq_out, 16'hFFFF, 0);
            else check("limit", max_freq_out, q_exp.pop_front(), q_tol.pop_front());
        end
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h9f60));
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        wr(SEL_CTRL, 16'h0002);
        wr(SEL_FILT, 16'h0001);
        go(16'($urandom_range(100, 400)), 1'b0, HIGH_FREQ_DEF, 0, 16'h0096);
        go(16'($urandom_range(1100, 2000)), 1'b0, MID_FREQ_DEF, 0, 16'h0096);
        go(16'h02EE, 1'b0, 16'h01C2, 3, 16'h0096);
        go(16'h00C8, 1'b1, MID_FREQ_DEF, 0, 16'h0096);
        go(16'h0005, 1'b0, MID_FREQ_DEF, 0, 16'h0096);
        $display("test load levels done");
        wr(SEL_CTRL, 16'h0003);
        wr(SEL_HIGH_FREQ, 16'h0226);
        wr(SEL_HIGH_FREQ, 16'h0FA1);
        go(16'h00C8, 1'b0, 16'h0226, 0, 16'h0096);
        wr(SEL_HIGH_FREQ, 16'h07D0);
        wr(SEL_AVG_RANGE, 16'h0190);
        go(16'h00C8, 1'b0, FREQ_CLAMP, 0, 16'h00C8);
        $display("test clamp and range done");
        for (int i = 0; i < 14; i++) begin
            @(posedge clk_in);
            if (i < 2) wr(SEL_CTRL, 16'(i));
            else inh <= 12'h001 << (i - 2);
            repeat (8) @(posedge clk_in);
            run_in <= 1'b1;
            repeat (40) @(posedge clk_in);
            #1;
            check("active", {15'h0000, active_out}, 16'h0000, 0);
            check("command", freq_cmd_out, freq_cmd_in, 0);
            @(posedge clk_in);
            run_in <= 1'b0;
            inh <= 12'h000;
            if (i == 1) wr(SEL_CTRL, 16'h0002);
        end
        $display("test disable conditions done");
        check("pending", 16'(q_exp.size()), 16'h0000, 0);
        complete_run();
    end
endmodule
